// file: hw/tdt_timing.sv
// Purpose: free-running dot/character/row/line timing for a text display
// Assumes: cursorEn comes from logic on the same clock
// Notes:   counts and flags are registered and always agree in time
//
// What this block does
// - dot counter cycles nine counts per character cell of nine by twelve.
// - character counter steps on each dot wrap, cycling 97 counts.
// - first 80 character counts are visible, last 17 horizontal retrace.
// - row counter steps per character wrap; 12 rows, 13 with cursor.
// - row twelve of every line except the seven-row mode line is flagged blank.
// - line counter steps per row wrap; frame totals 25 and 7/12 lines.
// - 24 full data lines plus one partial mode line.
// - line 25 is one extra line for vertical retrace.
// - all counters share one clock and cascade through enables.
// - the chain runs continuously with no start or stop control.
`default_nettype none

module tdt_timing (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // cursor compare request
  input  wire logic                cursorEn,
  // timing outputs
  output var tdt_pkg::tdt_counts_t counts,
  output var tdt_pkg::tdt_flags_t  flags,
  output var tdt_pkg::tdt_strobes_t strobes,
  output logic                     cursorLine
);

  // ****************************************
  // counter cascade
  // ****************************************
  logic [tdt_pkg::DOT_W-1:0]  dot;
  logic [tdt_pkg::DOT_W-1:0]  dotNxt;
  logic                       dotWrap;
  logic [tdt_pkg::CHR_W-1:0]  chr;
  logic [tdt_pkg::CHR_W-1:0]  chrNxt;
  logic                       chrWrap;
  logic [tdt_pkg::ROW_W-1:0]  row;
  logic [tdt_pkg::ROW_W-1:0]  rowNxt;
  logic                       rowWrap;
  logic [tdt_pkg::ROW_W-1:0]  rowLast;
  logic [tdt_pkg::LINE_W-1:0] line;
  logic [tdt_pkg::LINE_W-1:0] lineNxt;
  logic                       lineWrap;
  logic                       cursorLatch_r;
  logic                       cursorLatch_nxt;

  // dot stage has no enable: it runs every clock from power up
  tdt_wrap_counter #(.W(tdt_pkg::DOT_W)) u_dot (
    .clk      (clk),
    .rst      (rst),
    .en       (1'b1),
    .last     (tdt_pkg::DOT_LAST),
    .count    (dot),
    .countNxt (dotNxt),
    .wrap     (dotWrap)
  );

  // stages advance on enables, never on derived clocks
  tdt_wrap_counter #(.W(tdt_pkg::CHR_W)) u_chr (
    .clk      (clk),
    .rst      (rst),
    .en       (dotWrap),
    .last     (tdt_pkg::CHR_LAST),
    .count    (chr),
    .countNxt (chrNxt),
    .wrap     (chrWrap)
  );

  tdt_wrap_counter #(.W(tdt_pkg::ROW_W)) u_row (
    .clk      (clk),
    .rst      (rst),
    .en       (chrWrap),
    .last     (rowLast),
    .count    (row),
    .countNxt (rowNxt),
    .wrap     (rowWrap)
  );

  tdt_wrap_counter #(.W(tdt_pkg::LINE_W)) u_line (
    .clk      (clk),
    .rst      (rst),
    .en       (rowWrap),
    .last     (tdt_pkg::LINE_LAST),
    .count    (line),
    .countNxt (lineNxt),
    .wrap     (lineWrap)
  );

  // partial mode line and full retrace line shape the frame
  tdt_row_limit u_limit (
    .line        (line),
    .cursorLatch (cursorLatch_r),
    .rowLast     (rowLast)
  );

  // ****************************************
  // cursor request latch
  // ****************************************
  // a mid-line change would stretch or cut a line already being painted,
  // so the request is taken only as a new line begins
  always_comb begin
    cursorLatch_nxt = cursorLatch_r;
    if (rowWrap) begin
      cursorLatch_nxt = cursorEn;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cursorLatch_r <= 1'b0;
    end else begin
      cursorLatch_r <= cursorLatch_nxt;
    end
  end

  // ****************************************
  // flag decode
  // ****************************************
  function automatic tdt_pkg::tdt_flags_t decodeFlags(
    input logic [tdt_pkg::CHR_W-1:0]  c,
    input logic [tdt_pkg::ROW_W-1:0]  r,
    input logic [tdt_pkg::LINE_W-1:0] l
  );
    tdt_pkg::tdt_flags_t f;
    f           = '0;
    f.visible   = (c < tdt_pkg::CHR_VISIBLE);
    f.hRetrace  = (c >= tdt_pkg::CHR_VISIBLE);
    f.blankRow  = (r == tdt_pkg::ROW_BLANK);
    f.cursorRow = (r == tdt_pkg::ROW_CURSOR);
    f.modeLine  = (l == tdt_pkg::LINE_MODE);
    f.vRetrace  = (l == tdt_pkg::LINE_RETRACE);
    return f;
  endfunction : decodeFlags

  // flags are built from next counts so they line up with the counts
  always_ff @(posedge clk) begin
    if (rst) begin
      flags <= decodeFlags('0, '0, '0);
    end else begin
      flags <= decodeFlags(chrNxt, rowNxt, lineNxt);
    end
  end

  // ****************************************
  // boundary strobes
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      strobes <= '0;
    end else begin
      strobes.charStart  <= dotWrap;
      strobes.rowStart   <= chrWrap;
      strobes.lineStart  <= rowWrap;
      strobes.frameStart <= lineWrap;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign counts     = {dot, chr, row, line};
  assign cursorLine = cursorLatch_r;

  // ****************************************
  // checks
  // ****************************************
  logic [tdt_pkg::FRAME_W-1:0] frameCyc;

  always_ff @(posedge clk) begin
    if (rst || lineWrap) begin
      frameCyc <= '0;
    end else begin
      frameCyc <= frameCyc + tdt_pkg::FRAME_W'(1);
    end
  end

  // counters still hold their reset state on the first edge after release,
  // so step checks wait one more cycle before they start
  logic rstDly_r;

  always_ff @(posedge clk) begin
    rstDly_r <= rst;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || rstDly_r);

  property p_dot_wrap;
    dot == tdt_pkg::DOT_LAST |=> dot == 4'h0 ##8 dot == tdt_pkg::DOT_LAST;
  endproperty
  a_dot_wrap: assert property (p_dot_wrap) else $error("dot count is not nine long");

  property p_dot_step;
    dot != tdt_pkg::DOT_LAST |=> dot == $past(dot) + 4'h1;
  endproperty
  a_dot_step: assert property (p_dot_step) else $error("dot count skipped a clock");

  property p_chr_hold;
    dot != tdt_pkg::DOT_LAST |=> $stable(chr);
  endproperty
  a_chr_hold: assert property (p_chr_hold) else $error("character moved mid cell");

  property p_chr_wrap;
    chr == tdt_pkg::CHR_LAST && dotWrap |=> chr == 7'h00;
  endproperty
  a_chr_wrap: assert property (p_chr_wrap) else $error("character count not 97");

  property p_visible;
    flags.visible == (chr < tdt_pkg::CHR_VISIBLE) && flags.hRetrace == !flags.visible;
  endproperty
  a_visible: assert property (p_visible) else $error("visible flag disagrees with count");

  property p_row_normal;
    line < tdt_pkg::LINE_MODE && !cursorLatch_r && row == 4'hB && chrWrap |=> row == 4'h0;
  endproperty
  a_row_normal: assert property (p_row_normal) else $error("plain line not 12 rows");

  property p_row_cursor;
    line < tdt_pkg::LINE_MODE && cursorLatch_r && row == 4'hB && chrWrap |=> row == 4'hC;
  endproperty
  a_row_cursor: assert property (p_row_cursor) else $error("cursor line lacks row 13");

  property p_blank;
    flags.blankRow == (row == tdt_pkg::ROW_BLANK);
  endproperty
  a_blank: assert property (p_blank) else $error("blank row flag wrong");

  property p_mode_line;
    line == tdt_pkg::LINE_MODE && row == 4'h6 && chrWrap |=> line == tdt_pkg::LINE_RETRACE && row == 4'h0;
  endproperty
  a_mode_line: assert property (p_mode_line) else $error("mode line not 7 rows");

  property p_retrace;
    line == tdt_pkg::LINE_RETRACE && rowWrap |=> line == 5'h00 && flags.vRetrace == 1'b0;
  endproperty
  a_retrace: assert property (p_retrace) else $error("frame did not wrap after line 25");

  property p_frame_len;
    frameCyc < tdt_pkg::FRAME_W'(tdt_pkg::FRAME_CYCLES_MAX);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame longer than allowed");

  property p_latch_hold;
    !rowWrap |=> $stable(cursorLatch_r);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("cursor latch moved mid line");

  property p_reset;
    @(posedge clk) disable iff (1'b0) rst |=> counts == '0 && !cursorLatch_r;
  endproperty
  a_reset: assert property (p_reset) else $error("reset did not clear counters");

  property p_cursor_flag;
    flags.cursorRow == (row == tdt_pkg::ROW_CURSOR);
  endproperty
  a_cursor_flag: assert property (p_cursor_flag) else $error("cursor row flag wrong");

  property p_frame_flags;
    flags.modeLine == (line == tdt_pkg::LINE_MODE) && flags.vRetrace == (line == tdt_pkg::LINE_RETRACE);
  endproperty
  a_frame_flags: assert property (p_frame_flags) else $error("mode or retrace flag wrong");

  property p_line_strobe;
    rowWrap |=> strobes.lineStart && row == 4'h0 && cursorLatch_r == $past(cursorEn);
  endproperty
  a_line_strobe: assert property (p_line_strobe) else $error("line start or cursor latch wrong");

  property p_chr_strobe;
    chrWrap |=> strobes.rowStart && chr == 7'h00;
  endproperty
  a_chr_strobe: assert property (p_chr_strobe) else $error("row start strobe wrong");

  property p_char_pulse;
    strobes.charStart |=> !strobes.charStart;
  endproperty
  a_char_pulse: assert property (p_char_pulse) else $error("character strobe longer than one cycle");

  property p_row_hold;
    !chrWrap |=> $stable(row);
  endproperty
  a_row_hold: assert property (p_row_hold) else $error("row moved mid row");

  property p_line_hold;
    !rowWrap |=> $stable(line);
  endproperty
  a_line_hold: assert property (p_line_hold) else $error("line moved mid line");

  property p_retrace_rows;
    line == tdt_pkg::LINE_RETRACE && row == 4'hB && chrWrap |=> row == 4'h0 && line == 5'h00;
  endproperty
  a_retrace_rows: assert property (p_retrace_rows) else $error("retrace line not 12 rows");

  c_cursor_row: cover property (flags.cursorRow && flags.visible);
  c_mode_line:  cover property (flags.modeLine && row == tdt_pkg::ROW_LAST_MODE);
  c_retrace:    cover property (strobes.frameStart);
  c_cursor_chg: cover property (rowWrap && cursorEn != cursorLatch_r);
  c_line_cur:   cover property (strobes.lineStart && cursorLatch_r);

endmodule : tdt_timing

`default_nettype wire

// file: inc/tdt_pkg.sv
// Purpose: shared constants and carriers for the text display timing chain
// Assumes: one clock, synchronous active-high reset
// Notes:   all counts are zero based; row index 11 is the twelfth row
`default_nettype none

package tdt_pkg;

  // ****************************************
  // counter widths
  // ****************************************
  localparam int DOT_W  = 4;
  localparam int CHR_W  = 7;
  localparam int ROW_W  = 4;
  localparam int LINE_W = 5;

  // ****************************************
  // terminal counts and decode points
  // ****************************************
  localparam logic [DOT_W-1:0]  DOT_LAST        = 4'h8;  // 9 dots per cell
  localparam logic [CHR_W-1:0]  CHR_LAST        = 7'h60; // 97 character times
  localparam logic [CHR_W-1:0]  CHR_VISIBLE     = 7'h50; // first 80 are shown
  localparam logic [ROW_W-1:0]  ROW_LAST_NORMAL = 4'hB;  // 12 rows
  localparam logic [ROW_W-1:0]  ROW_LAST_CURSOR = 4'hC;  // 13 rows
  localparam logic [ROW_W-1:0]  ROW_BLANK       = 4'hB;  // twelfth row
  localparam logic [ROW_W-1:0]  ROW_CURSOR      = 4'hC;  // thirteenth row
  localparam logic [ROW_W-1:0]  ROW_LAST_MODE   = 4'h6;  // 7 of 12 rows
  localparam logic [LINE_W-1:0] LINE_MODE       = 5'h18; // partial line 24
  localparam logic [LINE_W-1:0] LINE_RETRACE    = 5'h19; // retrace line 25
  localparam logic [LINE_W-1:0] LINE_LAST       = 5'h19;

  // ****************************************
  // frame lengths in rows and clock cycles
  // ****************************************
  localparam int DATA_LINES       = 24;
  localparam int FRAME_ROWS_MIN   = DATA_LINES * 12 + 7 + 12;
  localparam int FRAME_ROWS_MAX   = DATA_LINES * 13 + 7 + 12;
  localparam int FRAME_CYCLES_MAX = 9 * 97 * FRAME_ROWS_MAX;
  localparam int FRAME_W          = 19;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [DOT_W-1:0]  dot;
    logic [CHR_W-1:0]  chr;
    logic [ROW_W-1:0]  row;
    logic [LINE_W-1:0] line;
  } tdt_counts_t;

  typedef struct packed {
    logic visible;
    logic hRetrace;
    logic blankRow;
    logic cursorRow;
    logic modeLine;
    logic vRetrace;
  } tdt_flags_t;

  typedef struct packed {
    logic charStart;
    logic rowStart;
    logic lineStart;
    logic frameStart;
  } tdt_strobes_t;

endpackage : tdt_pkg

`default_nettype wire

// file: hw/tdt_wrap_counter.sv
// Purpose: one stage of the display counter cascade
// Assumes: same clock for every stage; enable comes from the stage below
// Notes:   wrap is combinational so the next stage sees it in the same cycle
`default_nettype none

module tdt_wrap_counter #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // cascade control
  input  wire logic         en,
  input  wire logic [W-1:0] last,
  // count state
  output logic      [W-1:0] count,
  output logic      [W-1:0] countNxt,
  output logic              wrap
);

  assign wrap = en && (count == last);

  always_comb begin
    if (wrap) begin
      countNxt = '0;
    end else if (en) begin
      countNxt = count + W'(1);
    end else begin
      countNxt = count;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= countNxt;
    end
  end

endmodule : tdt_wrap_counter

`default_nettype wire

// file: hw/tdt_row_limit.sv
// Purpose: picks the last row index of the current line
// Assumes: cursor request already latched for the whole line
// Notes:   the mode line is cut short; the retrace line ignores the cursor
`default_nettype none

module tdt_row_limit (
  // line state
  input  wire logic [tdt_pkg::LINE_W-1:0] line,
  input  wire logic                       cursorLatch,
  // limit
  output logic      [tdt_pkg::ROW_W-1:0]  rowLast
);

  always_comb begin
    if (line == tdt_pkg::LINE_MODE) begin
      rowLast = tdt_pkg::ROW_LAST_MODE;
    end else if (line == tdt_pkg::LINE_RETRACE) begin
      rowLast = tdt_pkg::ROW_LAST_NORMAL;
    end else if (cursorLatch) begin
      rowLast = tdt_pkg::ROW_LAST_CURSOR;
    end else begin
      rowLast = tdt_pkg::ROW_LAST_NORMAL;
    end
  end

endmodule : tdt_row_limit

`default_nettype wire

// file: sim/tdt_cursor_model.sv
// Purpose: behavioural cursor compare logic that requests a thirteenth row
// Assumes: same clock as the timing chain; counts come straight from it
// Notes:   glitch inverts the request away from the row ends to prove it is ignored
`default_nettype none

module tdt_cursor_model (
  // clock
  input  wire logic                       clk,
  // timing seen from the chain
  input  wire tdt_pkg::tdt_counts_t       counts,
  // bench control
  input  wire logic [tdt_pkg::LINE_W-1:0] targetLine,
  input  wire logic                       glitch,
  // cursor request
  output logic                            cursorEn = 1'b0
);
  // ****************************************
  // request for the line after the current one
  // ****************************************
  always_ff @(posedge clk) begin
    // only the last character time of a row carries the true request
    cursorEn <= ((counts.line + 5'h01) == targetLine) ^ (glitch && (counts.chr != 7'h60));
  end
endmodule : tdt_cursor_model

`default_nettype wire

// file: sim/tdt_tb.sv
// Purpose: self-checking bench for the display timing chain
// Assumes: 125 MHz clock, synchronous active-high reset
// Notes:   a full frame is too long to run; the bench covers the first lines only
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic                        clk;
  logic                        rst;
  logic                        cursorEn;
  logic [tdt_pkg::LINE_W-1:0]  targetLine;
  logic                        glitch;
  tdt_pkg::tdt_counts_t        counts;
  tdt_pkg::tdt_flags_t         flags;
  tdt_pkg::tdt_strobes_t       strobes;
  logic                        cursorLine;
  int                          failCount = 0;
  int                          checksDone = 0;

  always #4 clk = ~clk;

  tdt_timing uut (
    .clk(clk), .rst(rst), .cursorEn(cursorEn),
    .counts(counts), .flags(flags), .strobes(strobes), .cursorLine(cursorLine)
  );

  tdt_cursor_model cursorModel (
    .clk(clk), .counts(counts), .targetLine(targetLine), .glitch(glitch), .cursorEn(cursorEn)
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      failCount++;
      $display("CHECK FAILED wait expected event seen timeout");
      give_verdict();
    end
  endtask : guard

  // ****************************************
  // scenarios
  // ****************************************
  task automatic check_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) step();
    cmp("counts", 16'h0000, 16'(counts));
    cmp("dot", 16'h0000, 16'(counts.dot));
    cmp("flags", 16'h0020, 16'(flags));
    cmp("strobes", 16'h0000, 16'(strobes));
    cmp("cursorLine", 16'h0000, 16'(cursorLine));
    @(posedge clk);
    rst <= 1'b0;
    #1;
  endtask : check_reset

  task automatic check_cell();
    for (int i = 1; i <= 9; i++) begin
      step();
      cmp("dot", 16'(i % 9), 16'(counts.dot));
      cmp("chr", 16'(i / 9), 16'(counts.chr));
      cmp("charStart", 16'(i == 9), 16'(strobes.charStart));
    end
    cmp("row", 16'h0000, 16'(counts.row));
  endtask : check_cell

  task automatic check_row();
    int n;
    for (n = 0; n < 1000 && counts.chr !== 7'h4F; n++) step();
    guard(n, 1000);
    cmp("visible", 16'h0001, 16'(flags.visible));
    cmp("hRetrace", 16'h0000, 16'(flags.hRetrace));
    repeat (9) step();
    cmp("visible", 16'h0000, 16'(flags.visible));
    cmp("hRetrace", 16'h0001, 16'(flags.hRetrace));
    for (n = 0; n < 1000 && strobes.rowStart !== 1'b1; n++) step();
    guard(n, 1000);
    cmp("chr", 16'h0000, 16'(counts.chr));
    cmp("row", 16'h0001, 16'(counts.row));
    cmp("visible", 16'h0001, 16'(flags.visible));
  endtask : check_row

  // measures one whole line from its start strobe to the next one
  task automatic check_line(input int expLine, input int expRows);
    int n;
    for (n = 0; n < 12000 && strobes.lineStart !== 1'b1; n++) step();
    guard(n, 12000);
    cmp("line", 16'(expLine), 16'(counts.line));
    cmp("cursorLine", 16'(expRows == 13), 16'(cursorLine));
    n = 0;
    do begin
      cmp("blankRow", 16'(counts.row == 4'hB), 16'(flags.blankRow));
      cmp("cursorRow", 16'(counts.row == 4'hC), 16'(flags.cursorRow));
      cmp("frameFlags", 16'h0000, 16'({flags.modeLine, flags.vRetrace, strobes.frameStart}));
      step();
      n++;
    end while (strobes.lineStart !== 1'b1 && n < 12000);
    cmp("lineCycles", 16'(expRows * 873), 16'(n));
  endtask : check_line

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    targetLine = 5'h02;
    glitch = 1'b1;
    check_reset();
    check_cell();
    check_row();
    check_line(1, 12);
    check_line(2, 13);
    check_line(3, 12);
    check_reset();
    check_cell();
    give_verdict();
  end
endmodule : tb

`default_nettype wire
